// >>> xbridge_consts.vh
/*
 Constants for the cross-bridge I/O and access decode block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef XBRIDGE_CONSTS_VH
`define XBRIDGE_CONSTS_VH
// Register offsets
`define OFF_CMD 8'h00
`define OFF_CTRL 8'h04
`define OFF_IOWIN 8'h08
`define OFF_MEMTOP 8'h0C
`define OFF_APER 8'h10
`define OFF_MWIN 8'h14
`define OFF_PWIN 8'h18
`define OFF_COMPAT 8'h1C
`define OFF_STAT 8'h20
// Field positions
`define CMD_IO_EN 0
`define CMD_MEM_EN 1
`define CTRL_VGA_EN 0
`define CTRL_MONO 1
`define STAT_INVALID 0
`define STAT_HUB_ABORT 1
// Reset values
`define RST_CMD 32'h0000_0000
`define RST_CTRL 32'h0000_0000
`define RST_IOWIN 32'h0000_0000
`define RST_MEMTOP 32'h0000_0000
`define RST_APER 32'h0000_0000
`define RST_MWIN 32'h0000_0000
`define RST_PWIN 32'h0000_0000
`define RST_COMPAT 32'h0000_0000
// Fixed address figures
`define IO_CFG_ADDR 16'h0CF8
`define IO_CFG_DATA 16'h0CFC
`define COMPAT_LO 32'h000A_0000
`define COMPAT_HI 32'h000F_FFFF
`define LEGACY_LO 32'h000C_0000
`define BLOCK_SHIFT 5
`define PAGE_MASK 32'h0000_0FFF
// Destinations
`define DST_HUB 2'd0
`define DST_PORT 2'd1
`define DST_SELF 2'd2
`endif

// >>> xbridge_decode.v
/*
 Address decode and routing of a host bridge: processor I/O steering,
 hub-link inbound checks, graphics-port inbound checks.
 Assumes every request port is synchronous to REF_CLK and one cycle wide.
*/
`timescale 1ns/10ps
`include "xbridge_consts.vh"
module xbridge_decode #(
  parameter HUB_BLK_SHIFT = 6
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire [7:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  input wire IO_REQ,
  input wire IO_WRITE,
  input wire [15:0] IO_ADDR,
  input wire IO_WRAP,
  input wire IO_DISK,
  output reg IO_VALID,
  output reg [1:0] IO_DEST,
  output reg [16:0] IO_OUT_ADDR,
  output reg IO_NONPOSTED,
  input wire IO_DONE,
  output wire IO_CPU_DONE,
  input wire HUB_REQ,
  input wire HUB_IS_IO,
  input wire HUB_WRITE,
  input wire [35:0] HUB_ADDR,
  input wire [8:0] HUB_LEN,
  output reg HUB_VALID,
  output reg [31:0] HUB_OUT_ADDR,
  output reg HUB_BE_ON,
  output reg HUB_SNOOP,
  output reg HUB_ABORT,
  output reg HUB_DROP,
  output reg HUB_ALL_ONES,
  output reg [7:0] HUB_BLK_BAD,
  input wire PORT_REQ,
  input wire PORT_PIPE,
  input wire [1:0] PORT_KIND,
  input wire PORT_WRITE,
  input wire PORT_CFG_SELF,
  input wire [31:0] PORT_ADDR,
  input wire [8:0] PORT_LEN,
  output reg PORT_CLAIM,
  output reg [31:0] PORT_OUT_ADDR,
  output reg PORT_BE_ON,
  output reg PORT_SNOOP,
  output reg [7:0] PORT_BLK_BAD,
  input wire [31:0] PORT_CUR_ADDR,
  input wire PORT_XFER,
  output wire PORT_DISCONNECT
);
  localparam KIND_MEM = 2'd0;
  localparam KIND_IO = 2'd1;
  localparam KIND_SPECIAL = 2'd2;
  localparam KIND_CFG = 2'd3;
  localparam T_NONE = 2'd0;
  localparam T_MEM = 2'd1;
  localparam T_APER = 2'd2;
  localparam T_PORT = 2'd3;
  localparam IO_IDLE = 2'b01;
  localparam IO_WAIT = 2'b10;
  reg [31:0] cmd_q;
  reg [31:0] ctrl_q;
  reg [31:0] iowin_q;
  reg [31:0] memtop_q;
  reg [31:0] aper_q;
  reg [31:0] mwin_q;
  reg [31:0] pwin_q;
  reg [31:0] compat_q;
  reg inv_flag_q;
  reg hub_abort_flag_q;
  reg [1:0] io_st_q;
  reg [1:0] io_st_d;
  wire io_en = cmd_q[`CMD_IO_EN];
  wire mem_en = cmd_q[`CMD_MEM_EN];
  wire vga_en = ctrl_q[`CTRL_VGA_EN];
  wire mono = ctrl_q[`CTRL_MONO];
  // Memory target of one address
  function [1:0] mem_target;
    input [31:0] a;
    input for_port;
    begin
      if (a[31:20] >= aper_q[31:20] && a[31:20] <= aper_q[15:4] && aper_q[31:20] != 12'h000)
        mem_target = T_APER;
      else if (a < {memtop_q[31:20], 20'h0_0000})
        mem_target = T_MEM;
      else if (!for_port && mem_en &&
               ((a[31:20] >= mwin_q[15:4] && a[31:20] <= mwin_q[31:20]) ||
                (a[31:20] >= pwin_q[15:4] && a[31:20] <= pwin_q[31:20])))
        mem_target = T_PORT;
      else
        mem_target = T_NONE;
    end
  endfunction
  function is_compat;
    input [31:0] a;
    begin
      is_compat = (a >= `COMPAT_LO) && (a <= `COMPAT_HI);
    end
  endfunction
  // Index of a 16 kB legacy segment into the attribute bit pairs
  function [3:0] compat_idx;
    input [31:0] a;
    begin
      compat_idx = (a < `LEGACY_LO) ? 4'd0 : a[17:14] + 4'd0;
    end
  endfunction
  // I/O routing
  // Monochrome adapter port addresses
  function mono_port;
    input [15:0] a;
    begin
      case (a)
        16'h03B4, 16'h03B5, 16'h03B8: mono_port = 1'b1;
        16'h03B9, 16'h03BA, 16'h03BF: mono_port = 1'b1;
        default: mono_port = 1'b0;
      endcase
    end
  endfunction
  wire io_mono = mono_port(IO_ADDR);
  wire io_vga = (IO_ADDR[15:10] == 6'd0) && (IO_ADDR[9:4] >= 6'h3B) && (IO_ADDR[9:4] <= 6'h3D);
  wire win_ok = iowin_q[15:12] >= iowin_q[7:4];
  wire io_win = win_ok && IO_ADDR[15:12] >= iowin_q[7:4] && IO_ADDR[15:12] <= iowin_q[15:12];
  wire io_self = (IO_ADDR[15:2] == `IO_CFG_ADDR >> 2) || (IO_ADDR[15:2] == `IO_CFG_DATA >> 2);
  reg [1:0] io_dest_c;
  always @* begin
    io_dest_c = `DST_HUB;
    if (io_self)
      io_dest_c = `DST_SELF;
    else if (mono && io_mono)
      io_dest_c = `DST_HUB;
    else if (io_en && vga_en && io_vga)
      io_dest_c = `DST_PORT;
    else if (io_en && io_win)
      io_dest_c = `DST_PORT;
  end
  always @* begin
    io_st_d = io_st_q;
    case (io_st_q)
      IO_IDLE: if (IO_REQ && IO_WRITE && IO_DISK) io_st_d = IO_WAIT;
      IO_WAIT: if (IO_DONE) io_st_d = IO_IDLE;
      default: io_st_d = IO_IDLE;
    endcase
  end
  // Disk writes finish only once the target reports done
  assign IO_CPU_DONE = (io_st_q == IO_WAIT) ? IO_DONE : IO_VALID && !IO_NONPOSTED;
  // Hub-link checks
  wire [35:0] hub_last36 = HUB_ADDR + {27'd0, HUB_LEN} - 36'd1;
  wire [31:0] hub_last = hub_last36[31:0];
  wire [1:0] hub_t0 = mem_target(HUB_ADDR[31:0], 1'b0);
  wire hub_vga = HUB_ADDR[31:17] == 15'h0005 && vga_en && io_en;
  wire hub_ok0 = (hub_t0 == T_MEM || hub_t0 == T_APER) || (hub_t0 == T_PORT && HUB_WRITE) ||
                 (hub_vga && HUB_WRITE);
  wire hub_high = HUB_ADDR[35:32] != 4'd0;
  wire [7:0] hub_bad_c;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : hub_blk
      wire [31:0] blk_a = ((HUB_ADDR[31:0] >> HUB_BLK_SHIFT) + g) << HUB_BLK_SHIFT;
      wire used = (blk_a >> HUB_BLK_SHIFT) <= (hub_last >> HUB_BLK_SHIFT);
      // Blocks off the starting target are bad; invalid start spoils all
      assign hub_bad_c[g] = used && (!hub_ok0 || (g != 0 && mem_target(blk_a, 1'b0) != hub_t0));
    end
  endgenerate
  // Graphics-port checks
  wire [1:0] port_t = mem_target(PORT_ADDR, 1'b1);
  wire [1:0] cpair = compat_q[{compat_idx(PORT_ADDR), 1'b0} +: 2];
  wire compat_ok = PORT_WRITE ? cpair[1] : cpair[0];
  wire port_mem = port_t == T_MEM || port_t == T_APER;
  wire port_claim_c = PORT_KIND == KIND_CFG ? PORT_CFG_SELF :
                      PORT_KIND != KIND_MEM ? 1'b0 :
                      is_compat(PORT_ADDR) ? compat_ok : port_mem;
  wire [31:0] port_last = PORT_ADDR + {23'd0, PORT_LEN} - 32'd1;
  wire [7:0] port_bad_c;
  generate
    for (g = 0; g < 8; g = g + 1) begin : port_blk
      wire [31:0] blk_a = ((PORT_ADDR >> `BLOCK_SHIFT) + g) << `BLOCK_SHIFT;
      wire used = (blk_a >> `BLOCK_SHIFT) <= (port_last >> `BLOCK_SHIFT);
      wire [1:0] t = mem_target(blk_a, 1'b1);
      assign port_bad_c[g] = used && ((t != T_MEM && t != T_APER) || is_compat(blk_a));
    end
  endgenerate
  // Disconnect when the next data phase opens a new 4 kB page
  assign PORT_DISCONNECT = PORT_XFER && ((PORT_CUR_ADDR & `PAGE_MASK) == 32'h0000_0FFC);
  // Hub-link response for the request in this cycle
  reg hub_valid_d;
  reg [31:0] hub_out_addr_d;
  reg hub_be_on_d;
  reg hub_snoop_d;
  reg hub_abort_d;
  reg hub_drop_d;
  reg hub_all_ones_d;
  reg [7:0] hub_blk_bad_d;
  always @* begin
    hub_valid_d = 1'b0;
    hub_out_addr_d = HUB_ADDR[31:0];
    hub_be_on_d = 1'b1;
    hub_snoop_d = 1'b0;
    hub_abort_d = 1'b0;
    hub_drop_d = 1'b0;
    hub_all_ones_d = 1'b0;
    hub_blk_bad_d = 8'h00;
    if (HUB_REQ) begin
      hub_blk_bad_d = hub_bad_c;
      if (HUB_IS_IO) begin
        hub_abort_d = 1'b1;
      end else if (hub_high) begin
        hub_out_addr_d = 32'h0000_0000;
        hub_valid_d = !HUB_WRITE;
        hub_be_on_d = !HUB_WRITE;
        hub_abort_d = !HUB_WRITE;
        hub_drop_d = HUB_WRITE;
      end else begin
        hub_valid_d = 1'b1;
        hub_snoop_d = 1'b1;
        hub_abort_d = hub_bad_c != 8'h00;
        hub_all_ones_d = !HUB_WRITE && hub_bad_c != 8'h00;
        if (!hub_ok0) begin
          hub_out_addr_d = 32'h0000_0000;
          hub_be_on_d = !HUB_WRITE;
        end
      end
    end
  end
  // Graphics-port response for the request in this cycle
  reg port_claim_d;
  reg [31:0] port_out_addr_d;
  reg port_be_on_d;
  reg [7:0] port_blk_bad_d;
  always @* begin
    port_claim_d = 1'b0;
    port_out_addr_d = PORT_ADDR;
    port_be_on_d = 1'b1;
    port_blk_bad_d = 8'h00;
    if (PORT_REQ && PORT_PIPE) begin
      port_claim_d = 1'b1;
      port_blk_bad_d = port_bad_c;
      if (port_bad_c[0]) begin
        port_out_addr_d = 32'h0000_0000;
        port_be_on_d = !PORT_WRITE;
      end
    end else if (PORT_REQ) begin
      port_claim_d = port_claim_c;
    end
  end
  // Configuration registers and read port
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_q <= `RST_CMD;
      ctrl_q <= `RST_CTRL;
      iowin_q <= `RST_IOWIN;
      memtop_q <= `RST_MEMTOP;
      aper_q <= `RST_APER;
      mwin_q <= `RST_MWIN;
      pwin_q <= `RST_PWIN;
      compat_q <= `RST_COMPAT;
      REG_RDATA <= 32'h0000_0000;
    end else begin
      if (REG_WR) begin
        case (REG_ADDR)
          `OFF_CMD: cmd_q <= REG_WDATA & 32'h0000_0003;
          `OFF_CTRL: ctrl_q <= REG_WDATA & 32'h0000_0003;
          `OFF_IOWIN: iowin_q <= REG_WDATA & 32'h0000_F0F0;
          `OFF_MEMTOP: memtop_q <= REG_WDATA & 32'hFFF0_0000;
          `OFF_APER: aper_q <= REG_WDATA & 32'hFFF0_FFF0;
          `OFF_MWIN: mwin_q <= REG_WDATA & 32'hFFF0_FFF0;
          `OFF_PWIN: pwin_q <= REG_WDATA & 32'hFFF0_FFF0;
          `OFF_COMPAT: compat_q <= REG_WDATA;
          default: ;
        endcase
      end
      if (REG_RD) begin
        case (REG_ADDR)
          `OFF_CMD: REG_RDATA <= cmd_q;
          `OFF_CTRL: REG_RDATA <= ctrl_q;
          `OFF_IOWIN: REG_RDATA <= iowin_q;
          `OFF_MEMTOP: REG_RDATA <= memtop_q;
          `OFF_APER: REG_RDATA <= aper_q;
          `OFF_MWIN: REG_RDATA <= mwin_q;
          `OFF_PWIN: REG_RDATA <= pwin_q;
          `OFF_COMPAT: REG_RDATA <= compat_q;
          `OFF_STAT: REG_RDATA <= {30'd0, hub_abort_flag_q, inv_flag_q};
          default: REG_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Error flags: set wins over write-one-to-clear
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      inv_flag_q <= 1'b0;
      hub_abort_flag_q <= 1'b0;
    end else begin
      if (PORT_REQ && PORT_PIPE && port_bad_c != 8'h00)
        inv_flag_q <= 1'b1;
      else if (REG_WR && REG_ADDR == `OFF_STAT && REG_WDATA[`STAT_INVALID])
        inv_flag_q <= 1'b0;
      if (HUB_REQ && (HUB_IS_IO || hub_bad_c != 8'h00 || hub_high))
        hub_abort_flag_q <= 1'b1;
      else if (REG_WR && REG_ADDR == `OFF_STAT && REG_WDATA[`STAT_HUB_ABORT])
        hub_abort_flag_q <= 1'b0;
    end
  end
  // Processor I/O forwarding
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      io_st_q <= IO_IDLE;
      IO_VALID <= 1'b0;
      IO_DEST <= `DST_HUB;
      IO_OUT_ADDR <= 17'h0_0000;
      IO_NONPOSTED <= 1'b0;
    end else begin
      io_st_q <= io_st_d;
      IO_VALID <= IO_REQ && io_dest_c != `DST_SELF;
      IO_DEST <= io_dest_c;
      IO_OUT_ADDR <= {IO_WRAP, IO_ADDR};
      IO_NONPOSTED <= IO_REQ && IO_WRITE && IO_DISK;
    end
  end
  // Hub-link answer registers
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HUB_VALID <= 1'b0;
      HUB_OUT_ADDR <= 32'h0000_0000;
      HUB_BE_ON <= 1'b0;
      HUB_SNOOP <= 1'b0;
      HUB_ABORT <= 1'b0;
      HUB_DROP <= 1'b0;
      HUB_ALL_ONES <= 1'b0;
      HUB_BLK_BAD <= 8'h00;
    end else begin
      HUB_VALID <= hub_valid_d;
      HUB_OUT_ADDR <= hub_out_addr_d;
      HUB_BE_ON <= hub_be_on_d;
      HUB_SNOOP <= hub_snoop_d;
      HUB_ABORT <= hub_abort_d;
      HUB_DROP <= hub_drop_d;
      HUB_ALL_ONES <= hub_all_ones_d;
      HUB_BLK_BAD <= hub_blk_bad_d;
    end
  end
  // Graphics-port answer registers
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PORT_CLAIM <= 1'b0;
      PORT_OUT_ADDR <= 32'h0000_0000;
      PORT_BE_ON <= 1'b0;
      PORT_SNOOP <= 1'b0;
      PORT_BLK_BAD <= 8'h00;
    end else begin
      PORT_CLAIM <= port_claim_d;
      PORT_OUT_ADDR <= port_out_addr_d;
      PORT_BE_ON <= port_be_on_d;
      PORT_SNOOP <= 1'b0;
      PORT_BLK_BAD <= port_blk_bad_d;
    end
  end
endmodule

// >>> xbridge_monitor.sv
/*
 Port checker for xbridge_decode.
 Assumes a single clock domain and the bind at the foot of this file.
*/
`timescale 1ns/10ps
module xbridge_monitor (
  input wire REF_CLK,
  input wire RST_N,
  input wire IO_REQ,
  input wire IO_WRITE,
  input wire [15:0] IO_ADDR,
  input wire IO_WRAP,
  input wire IO_DISK,
  input wire [1:0] IO_DEST,
  input wire [16:0] IO_OUT_ADDR,
  input wire IO_NONPOSTED,
  input wire IO_DONE,
  input wire IO_CPU_DONE,
  input wire HUB_REQ,
  input wire HUB_IS_IO,
  input wire HUB_WRITE,
  input wire [35:0] HUB_ADDR,
  input wire HUB_ABORT,
  input wire HUB_DROP,
  input wire PORT_REQ,
  input wire PORT_PIPE,
  input wire [1:0] PORT_KIND,
  input wire PORT_CFG_SELF,
  input wire PORT_CLAIM,
  input wire PORT_SNOOP,
  input wire [31:0] PORT_CUR_ADDR,
  input wire PORT_XFER,
  input wire PORT_DISCONNECT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_disk_wr;
    IO_REQ && IO_WRITE && IO_DISK;
  endsequence
  sequence s_wait;
    IO_NONPOSTED && !IO_DONE;
  endsequence
  a_io_addr_pass: assert property (IO_REQ |=> IO_OUT_ADDR == {$past(IO_WRAP), $past(IO_ADDR)})
    else $error("io address altered");
  a_io_not_self: assert property (IO_REQ && IO_ADDR[15:3] != 13'h019f |=> IO_DEST != 2'd2)
    else $error("io cycle kept internally");
  a_disk_np: assert property (s_disk_wr |=> IO_NONPOSTED)
    else $error("disk write posted");
  a_disk_hold: assert property (s_disk_wr ##1 s_wait |-> !IO_CPU_DONE)
    else $error("cpu done before target");
  a_hub_io: assert property (HUB_REQ && HUB_IS_IO |=> HUB_ABORT)
    else $error("hub io not aborted");
  a_hub_high: assert property (
    HUB_REQ && !HUB_IS_IO && HUB_ADDR[35:32] != 4'h0
    |=> ($past(HUB_WRITE) ? (HUB_DROP && !HUB_ABORT) : HUB_ABORT))
    else $error("hub above 4 GB");
  a_port_noio: assert property (
    PORT_REQ && (PORT_KIND == 2'd1 || PORT_KIND == 2'd2) |=> !PORT_CLAIM)
    else $error("port io claimed");
  a_port_cfg: assert property (PORT_REQ && PORT_KIND == 2'd3 && PORT_CFG_SELF |=> PORT_CLAIM)
    else $error("port config refused");
  a_pipe_snoop: assert property (PORT_REQ && PORT_PIPE |=> !PORT_SNOOP)
    else $error("pipelined cycle snooped");
  a_page_cut: assert property (
    PORT_XFER |-> PORT_DISCONNECT == (PORT_CUR_ADDR[11:2] == 10'h3ff))
    else $error("page disconnect wrong");
endmodule
bind xbridge_decode xbridge_monitor mon (.REF_CLK, .RST_N, .IO_REQ, .IO_WRITE, .IO_ADDR,
  .IO_WRAP, .IO_DISK, .IO_DEST, .IO_OUT_ADDR, .IO_NONPOSTED, .IO_DONE, .IO_CPU_DONE,
  .HUB_REQ, .HUB_IS_IO, .HUB_WRITE, .HUB_ADDR, .HUB_ABORT, .HUB_DROP, .PORT_REQ,
  .PORT_PIPE, .PORT_KIND, .PORT_CFG_SELF, .PORT_CLAIM, .PORT_SNOOP, .PORT_CUR_ADDR,
  .PORT_XFER, .PORT_DISCONNECT);

// >>> io_target_model.sv
/*
 Far-side I/O target: completes a held write after a chosen lag.
 Assumes forward and hold pulses one cycle wide.
*/
`timescale 1ns/10ps
module io_target_model (
  input wire clk,
  input wire rst_n,
  input wire fwd,
  input wire hold,
  input wire [3:0] lag,
  output reg done
);
  reg [3:0] cnt_q;
  reg busy_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= busy_q && cnt_q <= 4'h1;
      if (fwd && hold) begin
        busy_q <= 1'b1;
        cnt_q <= lag;
      end else if (busy_q) begin
        busy_q <= cnt_q > 4'h1;
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// >>> cross_bridge_io_and_access_decode_test.sv
/*
 Self-checking bench for xbridge_decode with a far-side target model.
 Assumes the constants header and the checker are compiled alongside.
*/
`timescale 1ns/10ps
`include "xbridge_consts.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module cross_bridge_io_and_access_decode_test;
  reg REF_CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, IO_REQ = 0, IO_WRITE = 0, IO_WRAP = 0;
  reg IO_DISK = 0, HUB_REQ = 0, HUB_IS_IO = 0, HUB_WRITE = 0, PORT_REQ = 0, PORT_PIPE = 0;
  reg PORT_WRITE = 0, PORT_CFG_SELF = 0, PORT_XFER = 0;
  reg [7:0] REG_ADDR = 0;
  reg [31:0] REG_WDATA = 0, PORT_ADDR = 0, PORT_CUR_ADDR = 0, rd, x;
  reg [15:0] IO_ADDR = 0, a;
  reg [35:0] HUB_ADDR = 0;
  reg [8:0] HUB_LEN = 1, PORT_LEN = 1;
  reg [1:0] PORT_KIND = 0;
  reg [3:0] lag = 1;
  wire [31:0] REG_RDATA, HUB_OUT_ADDR, PORT_OUT_ADDR;
  wire [16:0] IO_OUT_ADDR;
  wire [1:0] IO_DEST;
  wire [7:0] HUB_BLK_BAD, PORT_BLK_BAD;
  wire IO_VALID, IO_NONPOSTED, IO_DONE, IO_CPU_DONE, HUB_VALID, HUB_BE_ON, HUB_SNOOP;
  wire HUB_ABORT, HUB_DROP, HUB_ALL_ONES, PORT_CLAIM, PORT_BE_ON, PORT_SNOOP, PORT_DISCONNECT;
  int n_errors = 0, num_checks = 0, cyc = 0, seed = 32'hf52b, io_en, vga, mono, lo, hi, i, k;
  int cmdv[4] = '{1, 0, 1, 1}, ctrlv[4] = '{0, 0, 3, 1}, winv[4] = '{'h3020, 'h3020, 'h2030, 'h2030};
  int al[10] = '{'h3b4, 'h3c0, 'hcf8, 'hcff, 'h2000, 'h3fff, 'h1fff, 'h4000, 'h3bf, 'h3b0};
  xbridge_decode uut (.REF_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .IO_REQ, .IO_WRITE, .IO_ADDR, .IO_WRAP, .IO_DISK, .IO_VALID, .IO_DEST, .IO_OUT_ADDR,
    .IO_NONPOSTED, .IO_DONE, .IO_CPU_DONE, .HUB_REQ, .HUB_IS_IO, .HUB_WRITE, .HUB_ADDR,
    .HUB_LEN, .HUB_VALID, .HUB_OUT_ADDR, .HUB_BE_ON, .HUB_SNOOP, .HUB_ABORT, .HUB_DROP,
    .HUB_ALL_ONES, .HUB_BLK_BAD, .PORT_REQ, .PORT_PIPE, .PORT_KIND, .PORT_WRITE,
    .PORT_CFG_SELF, .PORT_ADDR, .PORT_LEN, .PORT_CLAIM, .PORT_OUT_ADDR, .PORT_BE_ON,
    .PORT_SNOOP, .PORT_BLK_BAD, .PORT_CUR_ADDR, .PORT_XFER, .PORT_DISCONNECT);
  io_target_model far (.clk(REF_CLK), .rst_n(RST_N), .fwd(IO_VALID), .hold(IO_NONPOSTED),
    .lag(lag), .done(IO_DONE));
  always #2 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task reg_wr(input [7:0] ad, input [31:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= ad;
    REG_WDATA <= d;
    REG_WR <= 1;
    @(posedge REF_CLK);
    REG_WR <= 0;
  endtask
  task reg_rd(input [7:0] ad);
    @(posedge REF_CLK);
    REG_ADDR <= ad;
    REG_RD <= 1;
    @(posedge REF_CLK);
    REG_RD <= 0;
    #1 rd = REG_RDATA;
  endtask
  task io_req(input [15:0] ad, input w, input wr, input dk);
    @(posedge REF_CLK);
    {IO_ADDR, IO_WRITE, IO_WRAP, IO_DISK, IO_REQ} <= {ad, w, wr, dk, 1'b1};
    @(posedge REF_CLK);
    IO_REQ <= 0;
    #1;
  endtask
  task hub_req(input io, input w, input [35:0] ad, input [8:0] ln);
    @(posedge REF_CLK);
    {HUB_IS_IO, HUB_WRITE, HUB_ADDR, HUB_LEN, HUB_REQ} <= {io, w, ad, ln, 1'b1};
    @(posedge REF_CLK);
    HUB_REQ <= 0;
    #1;
  endtask
  task port_req(input p, input [1:0] kd, input w, input cs, input [31:0] ad, input [8:0] ln);
    @(posedge REF_CLK);
    {PORT_PIPE, PORT_KIND, PORT_WRITE, PORT_CFG_SELF} <= {p, kd, w, cs};
    {PORT_ADDR, PORT_LEN, PORT_REQ} <= {ad, ln, 1'b1};
    @(posedge REF_CLK);
    PORT_REQ <= 0;
    #1;
  endtask
  function [1:0] io_dst(input [15:0] y);
    if (y[15:3] == 13'h019f) return 2'd2;
    if (mono && (y inside {16'h03b4, 16'h03b5, 16'h03b8, 16'h03b9, 16'h03ba, 16'h03bf}))
      return 2'd0;
    if (io_en && lo <= y[15:12] && y[15:12] <= hi) return 2'd1;
    if (io_en && vga && y >= 16'h03b0 && y <= 16'h03df) return 2'd1;
    return 2'd0;
  endfunction
  initial begin
    repeat (6) @(posedge REF_CLK);
    RST_N <= 1;
    for (i = 0; i <= 36; i += 4) begin
      reg_rd(i);
      `CHK(rd, 32'h0000_0000)
    end
    for (k = 0; k < 4; k++) begin
      {io_en, vga, mono, lo, hi} = {cmdv[k] & 1, ctrlv[k] & 1, ctrlv[k] >> 1,
        (winv[k] >> 4) & 15, winv[k] >> 12};
      reg_wr(`OFF_CMD, cmdv[k]);
      reg_wr(`OFF_CTRL, ctrlv[k]);
      reg_wr(`OFF_IOWIN, winv[k]);
      for (i = 0; i < 14; i++) begin
        a = (i < 10) ? al[i] : $random(seed);
        io_req(a, 0, 0, 0);
        `CHK(IO_DEST, io_dst(a))
        `CHK(IO_VALID, io_dst(a) != 2'd2)
        `CHK(IO_OUT_ADDR, {1'b0, a})
      end
    end
    io_req(16'hffff, 0, 1, 0);
    `CHK(IO_OUT_ADDR, 17'h1_ffff)
    io_req(16'h0080, 1, 0, 0);
    `CHK({IO_NONPOSTED, IO_CPU_DONE}, 2'b01)
    for (lag = 1; lag < 8; lag += 6) begin
      io_req(16'h01f0, 1, 0, 1);
      `CHK({IO_NONPOSTED, IO_CPU_DONE}, 2'b10)
      for (k = 0; k < 30 && !IO_CPU_DONE; k++) @(posedge REF_CLK) #1;
      `CHK(IO_DONE, 1'b1)
    end
    $display("io routing done");
    reg_wr(`OFF_MEMTOP, 32'h0100_0000);
    reg_wr(`OFF_CMD, 3);
    hub_req(1, 0, 36'h100, 4);
    `CHK({HUB_ABORT, HUB_VALID}, 2'b10)
    hub_req(0, 0, 36'h1_0000_0000, 4);
    `CHK(HUB_ABORT, 1'b1)
    hub_req(0, 1, 36'h1_0000_0000, 4);
    `CHK({HUB_DROP, HUB_ABORT, HUB_VALID}, 3'b100)
    hub_req(0, 0, 36'h1000, 64);
    `CHK({HUB_OUT_ADDR, HUB_ABORT, HUB_VALID}, {32'h0000_1000, 2'b01})
    hub_req(0, 0, 36'hff_ffc0, 128);
    `CHK(HUB_BLK_BAD, 8'h02)
    hub_req(0, 1, 36'h200_0000, 4);
    `CHK({HUB_OUT_ADDR, HUB_BE_ON, HUB_SNOOP}, {32'h0000_0000, 2'b01})
    hub_req(0, 0, 36'h200_0000, 256);
    `CHK({HUB_ALL_ONES, HUB_ABORT}, 2'b11)
    $display("hub decode done");
    port_req(1, 0, 1, 0, 32'h0200_0000, 32);
    `CHK({PORT_OUT_ADDR, PORT_BE_ON, PORT_SNOOP}, {32'h0000_0000, 2'b00})
    reg_rd(`OFF_STAT);
    `CHK(rd[0], 1'b1)
    reg_wr(`OFF_STAT, 1);
    reg_rd(`OFF_STAT);
    `CHK(rd[0], 1'b0)
    port_req(1, 0, 0, 0, 32'h00ff_ffe0, 64);
    `CHK({PORT_OUT_ADDR, PORT_BLK_BAD}, {32'h00ff_ffe0, 8'h02})
    for (k = 1; k < 3; k++) begin
      port_req(0, k, 0, 0, 32'h3000, 4);
      `CHK(PORT_CLAIM, 1'b0)
    end
    port_req(0, 3, 0, 1, 0, 4);
    `CHK(PORT_CLAIM, 1'b1)
    port_req(0, 0, 1, 0, 32'h3000, 4);
    `CHK(PORT_CLAIM, 1'b1)
    port_req(0, 0, 0, 0, 32'h0200_0000, 4);
    `CHK(PORT_CLAIM, 1'b0)
    port_req(0, 0, 1, 0, 32'h000c_0000, 4);
    `CHK(PORT_CLAIM, 1'b0)
    reg_wr(`OFF_COMPAT, 32'hffff_ffff);
    port_req(0, 0, 1, 0, 32'h000c_0000, 4);
    `CHK(PORT_CLAIM, 1'b1)
    for (i = 0; i < 8; i++) begin
      x = (i == 0) ? 32'h0000_0ffc : (i == 1) ? 32'h0000_1ff8 : $random(seed);
      @(posedge REF_CLK);
      PORT_XFER <= 1;
      PORT_CUR_ADDR <= x;
      #1 `CHK(PORT_DISCONNECT, x[11:2] == 10'h3ff)
    end
    @(posedge REF_CLK);
    PORT_XFER <= 0;
    $display("port decode done");
    end_sim;
  end
endmodule
